// ==== hw/eirq_top.sv ====
// external interrupt request logic with entry and return sequencing
`timescale 1ns/100ps
module eirq_top import eirq_pkg::*; (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // request pins
    input  wire logic extReqMaskable_n,
    input  wire logic ext_req_nonmaskable_n,
    // cpu side
    input  wire logic otherReq,
    input  wire logic edgeSelWr,
    input  wire logic edgeSelData,
    input  wire logic globalMaskWr,
    input  wire logic globalMaskData,
    input  wire logic nmiEnableClr,
    input  wire logic returnFromInterrupt,
    // status
    output logic      edge_select_bit,
    output logic      globalMask,
    output logic      nmiDisable,
    output logic      inEntry,
    output logic      inHandler,
    output logic      inReturn,
    output logic      handlerStart,
    output logic      resumeStart,
    output eirq_src_type activeSrc
);
    ////////////////////////////////////////////////////////////////////
    eirq_state_type stateQ;
    logic [3:0] seqQ;
    logic [6:0] winQ;
    logic edgePend, extReq, nmiReq, take, takeExt, nmiBusyQ;
    logic maskSaveQ, otherBusy;
    eirq_src_type pick;
    logic [3:0] entryRunQ, retRunQ;
    ////////////////////////////////////////////////////////////////////
    // protection window counter
    always_ff @(posedge clock) begin
        if (!nrst) winQ <= WIN_W0;
        else if (winQ != WIN_LAST) winQ <= winQ + 7'h01;
    end
    always_ff @(posedge clock) begin
        if (!nrst) edge_select_bit <= 1'b1;
        else if (edgeSelWr && winQ != WIN_LAST)
            edge_select_bit <= edgeSelData;
    end
    ////////////////////////////////////////////////////////////////////
    // request recognition
    eirq_edge_latch u_edge (
        .clock (clock),
        .nrst  (nrst),
        .lineN (extReqMaskable_n),
        .clr   (takeExt),
        .pend  (edgePend)
    );
    assign extReq = edge_select_bit ? edgePend
                                    : !extReqMaskable_n;
    assign nmiReq = !ext_req_nonmaskable_n && !nmiDisable
                    && !nmiBusyQ;
    assign otherBusy = (stateQ != ST_RUN);
    always_comb begin
        pick = SRC_NONE;
        if (nmiReq) pick = SRC_NMI;
        else if (extReq && !globalMask) pick = SRC_EXT;
        else if (otherReq && !globalMask) pick = SRC_OTHER;
    end
    assign take = !otherBusy && pick != SRC_NONE;
    assign takeExt = take && pick == SRC_EXT;
    assign handlerStart = stateQ == ST_ENTRY && seqQ == ENTRY_LAST;
    assign resumeStart = stateQ == ST_RETURN && seqQ == RETURN_LAST;
    assign inEntry = stateQ == ST_ENTRY;
    assign inHandler = stateQ == ST_HANDLER;
    assign inReturn = stateQ == ST_RETURN;
    ////////////////////////////////////////////////////////////////////
    // service sequencer
    always_ff @(posedge clock) begin
        if (!nrst) begin
            stateQ <= ST_RUN;
            seqQ <= SEQ_W0;
        end else begin
            unique case (stateQ)
                ST_RUN: begin
                    seqQ <= SEQ_W0;
                    if (take) stateQ <= ST_ENTRY;
                end
                ST_ENTRY: begin
                    seqQ <= seqQ + 4'h1;
                    if (seqQ == ENTRY_LAST) begin
                        stateQ <= ST_HANDLER;
                        seqQ <= SEQ_W0;
                    end
                end
                ST_HANDLER: begin
                    if (returnFromInterrupt) stateQ <= ST_RETURN;
                end
                ST_RETURN: begin
                    seqQ <= seqQ + 4'h1;
                    if (seqQ == RETURN_LAST) begin
                        stateQ <= ST_RUN;
                        seqQ <= SEQ_W0;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge clock) begin
        if (!nrst) activeSrc <= SRC_NONE;
        else if (take) activeSrc <= pick;
        else if (resumeStart) activeSrc <= SRC_NONE;
    end
    always_ff @(posedge clock) begin
        if (!nrst) nmiBusyQ <= 1'b0;
        else if (take && pick == SRC_NMI) nmiBusyQ <= 1'b1;
        else if (resumeStart) nmiBusyQ <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // condition code bits
    always_ff @(posedge clock) begin
        if (!nrst) maskSaveQ <= 1'b1;
        else if (take) maskSaveQ <= globalMask;
    end
    always_ff @(posedge clock) begin
        if (!nrst) globalMask <= 1'b1;
        else if (take) globalMask <= 1'b1;
        else if (resumeStart) globalMask <= maskSaveQ;
        else if (globalMaskWr) globalMask <= globalMaskData;
    end
    always_ff @(posedge clock) begin
        if (!nrst) nmiDisable <= 1'b1;
        else if (nmiEnableClr) nmiDisable <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////
    // run lengths of entry and return, for the length checks
    always_ff @(posedge clock) begin
        if (!nrst) entryRunQ <= SEQ_W0;
        else if (!inEntry) entryRunQ <= SEQ_W0;
        else if (entryRunQ != 4'hF) entryRunQ <= entryRunQ + 4'h1;
    end
    always_ff @(posedge clock) begin
        if (!nrst) retRunQ <= SEQ_W0;
        else if (!inReturn) retRunQ <= SEQ_W0;
        else if (retRunQ != 4'hF) retRunQ <= retRunQ + 4'h1;
    end
    ////////////////////////////////////////////////////////////////////
    // checks
    property p_protect;
        @(posedge clock) disable iff (!nrst)
        winQ == WIN_LAST |=> $stable(edge_select_bit);
    endproperty
    a_protect: assert property (p_protect)
        else $error("edge select changed after window");
    property p_mask;
        @(posedge clock) disable iff (!nrst)
        take && pick == SRC_EXT |-> !globalMask;
    endproperty
    a_mask: assert property (p_mask)
        else $error("maskable taken while masked");
    property p_entry;
        @(posedge clock) disable iff (!nrst)
        take |=> inEntry ##11 (inEntry && handlerStart) ##1 inHandler;
    endproperty
    a_entry: assert property (p_entry)
        else $error("entry length wrong");
    property p_ret;
        @(posedge clock) disable iff (!nrst)
        inHandler && returnFromInterrupt |=> inReturn ##11
            (inReturn && resumeStart) ##1 stateQ == ST_RUN;
    endproperty
    a_ret: assert property (p_ret)
        else $error("return length wrong");
    property p_setmask;
        @(posedge clock) disable iff (!nrst)
        take |=> globalMask;
    endproperty
    a_setmask: assert property (p_setmask)
        else $error("mask not set on service");
    property p_nmi;
        @(posedge clock) disable iff (!nrst)
        stateQ == ST_RUN && !ext_req_nonmaskable_n && !nmiDisable
            && !nmiBusyQ |=> inEntry && activeSrc == SRC_NMI;
    endproperty
    a_nmi: assert property (p_nmi)
        else $error("nonmaskable not serviced");
    property p_nmidis;
        @(posedge clock) disable iff (!nrst)
        nmiDisable |-> pick != SRC_NMI;
    endproperty
    a_nmidis: assert property (p_nmidis)
        else $error("nonmaskable taken while disabled");
    property p_once;
        @(posedge clock) disable iff (!nrst)
        takeExt && edge_select_bit && extReqMaskable_n |=> !edgePend;
    endproperty
    a_once: assert property (p_once)
        else $error("edge latch not cleared");
    property p_busy;
        @(posedge clock) disable iff (!nrst)
        otherBusy |-> !take;
    endproperty
    a_busy: assert property (p_busy)
        else $error("taken during service");
    property p_entrylen;
        @(posedge clock) disable iff (!nrst)
        $fell(inEntry) |-> entryRunQ == 4'(ENTRY_CYCLES);
    endproperty
    a_entrylen: assert property (p_entrylen)
        else $error("entry run length wrong");
    property p_retlen;
        @(posedge clock) disable iff (!nrst)
        $fell(inReturn) |-> retRunQ == 4'(RETURN_CYCLES);
    endproperty
    a_retlen: assert property (p_retlen)
        else $error("return run length wrong");
    property p_level;
        @(posedge clock) disable iff (!nrst)
        stateQ == ST_RUN && !edge_select_bit && !extReqMaskable_n
            && !globalMask && !nmiReq
            |=> inEntry && activeSrc == SRC_EXT;
    endproperty
    a_level: assert property (p_level)
        else $error("level request not serviced");
    property p_restore;
        @(posedge clock) disable iff (!nrst)
        resumeStart |=> globalMask == $past(maskSaveQ);
    endproperty
    a_restore: assert property (p_restore)
        else $error("mask not restored on return");
endmodule

// ==== hw/eirq_pkg.sv ====
// package for the external interrupt request logic
// Functional notes
// - both request inputs are active low; a low line requests service
// - maskable request serviced only while global mask bit is clear
// - request arriving during another service waits until that service ends
// - maskable request has no local enable and no flag for software
// - enabled nonmaskable request serviced at once, global mask ignored
// - reset selects edge mode; falling edge latched, serviced once
// - edge-select cleared gives low-level recognition for wired-OR sources
// - edge-select writes accepted only in first 64 cycles after reset
// - nonmaskable request is level sensitive only
// - reset sets nonmaskable disable bit, disabling the nonmaskable request
// - enabled nonmaskable blocked only by a service in progress or reset
// - interrupt entry takes 12 cycles before the handler starts
// - return from interrupt takes 12 cycles before the program resumes
// - servicing saves state and sets the global mask bit
// - maskable external request has highest maskable priority by default
package eirq_pkg;
    localparam int unsigned PROTECT_CYCLES = 64;
    localparam int unsigned ENTRY_CYCLES   = 12;
    localparam int unsigned RETURN_CYCLES  = 12;
    localparam logic [6:0]  WIN_W0         = 7'h00;
    localparam logic [3:0]  SEQ_W0         = 4'h0;
    localparam logic [3:0]  ENTRY_LAST     = 4'(ENTRY_CYCLES - 1);
    localparam logic [3:0]  RETURN_LAST    = 4'(RETURN_CYCLES - 1);
    localparam logic [6:0]  WIN_LAST       = 7'(PROTECT_CYCLES);
    typedef enum logic [1:0] {SRC_NONE, SRC_EXT, SRC_NMI, SRC_OTHER}
        eirq_src_type;
    typedef enum {ST_RUN, ST_ENTRY, ST_HANDLER, ST_RETURN} eirq_state_type;
endpackage

// ==== hw/eirq_edge_latch.sv ====
// falling-edge catcher with clear, set winning
`timescale 1ns/100ps
module eirq_edge_latch (
    // clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // line and control
    input  wire logic lineN,
    input  wire logic clr,
    output logic      pend
);
    logic prevQ;
    always_ff @(posedge clock) begin
        if (!nrst) prevQ <= 1'b1;
        else prevQ <= lineN;
    end
    always_ff @(posedge clock) begin
        if (!nrst) pend <= 1'b0;
        else if (prevQ && !lineN) pend <= 1'b1;
        else if (clr) pend <= 1'b0;
    end
endmodule

// ==== verif/eirq_ext_src.sv ====
// model of outside sources pulling the request lines low
`timescale 1ns/100ps
module eirq_ext_src (
    // open-collector pull-down requests
    input  wire logic srcA,
    input  wire logic srcB,
    input  wire logic srcN,
    // request lines with pull-ups
    output logic      lineM_n,
    output logic      lineN_n
);
    assign lineM_n = ~(srcA | srcB);
    assign lineN_n = ~srcN;
endmodule

// ==== verif/eirq_tb_top.sv ====
// self-checking bench for the external request logic
`timescale 1ns/100ps
module eirq_tb_top import eirq_pkg::*;;
    logic clock = 1'b0, nrst = 1'b0, srcA = 1'b0, srcB = 1'b0;
    logic srcN = 1'b0, otherReq = 1'b0, eWr = 1'b0, eD = 1'b0;
    logic mWr = 1'b0, mD = 1'b0, nClr = 1'b0, rfi = 1'b0;
    logic lineM_n, lineN_n, eBit, gMask, nDis, inEntry, inRet;
    logic hStart, rStart, inHand;
    logic [7:0] lfsr = 8'h0C;
    eirq_src_type activeSrc;
    int fails = 0, n_compared = 0, tick = 0;
    eirq_ext_src eirq_ext_src_inst (.srcA(srcA), .srcB(srcB),
        .srcN(srcN), .lineM_n(lineM_n), .lineN_n(lineN_n));
    eirq_top eirq_top_inst (.clock(clock), .nrst(nrst),
        .extReqMaskable_n(lineM_n), .ext_req_nonmaskable_n(lineN_n),
        .otherReq(otherReq), .edgeSelWr(eWr), .edgeSelData(eD),
        .globalMaskWr(mWr), .globalMaskData(mD), .nmiEnableClr(nClr),
        .returnFromInterrupt(rfi), .edge_select_bit(eBit),
        .globalMask(gMask), .nmiDisable(nDis), .inEntry(inEntry),
        .inHandler(inHand), .inReturn(inRet), .handlerStart(hStart),
        .resumeStart(rStart), .activeSrc(activeSrc));
    ////////////////////////////////////////////////////////////////////
    always #50 clock = ~clock;
    always @(posedge clock) begin
        tick <= tick + 1;
        if (tick == 3000) begin
            fails++;
            summarize();
        end
    end
    function logic [7:0] nxt(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction
    task summarize;
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
    endtask
    task rst;
        nrst <= 1'b0;
        cyc(16);
        nrst <= 1'b1;
    endtask
    task wrm(input logic v);
        mD <= v;
        mWr <= 1'b1;
        cyc(1);
        mWr <= 1'b0;
        cyc(1);
    endtask
    task wre(input logic v);
        eD <= v;
        eWr <= 1'b1;
        cyc(1);
        eWr <= 1'b0;
        cyc(1);
    endtask
    // waits for a take, times entry and return
    task automatic isr(input eirq_src_type src);
        int n, hAt, rAt;
        n = 0;
        hAt = 99;
        rAt = 99;
        while (inEntry !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (inEntry === 1'b1 && n < 30) begin
            if (hStart === 1'b1) hAt = n;
            cyc(1);
            n++;
        end
        chk("entry", 8'(ENTRY_CYCLES), 8'(n));
        chk("hStart", 8'(ENTRY_CYCLES - 1), 8'(hAt));
        chk("inHandler", 8'h01, 8'(inHand));
        chk("src", 8'(src), 8'(activeSrc));
        chk("maskSet", 8'h01, 8'(gMask));
        rfi <= 1'b1;
        cyc(1);
        rfi <= 1'b0;
        n = 0;
        while (inRet !== 1'b1 && n < 20) begin
            cyc(1);
            n++;
        end
        n = 0;
        while (inRet === 1'b1 && n < 30) begin
            if (rStart === 1'b1) rAt = n;
            cyc(1);
            n++;
        end
        chk("return", 8'(RETURN_CYCLES), 8'(n));
        chk("rStart", 8'(RETURN_CYCLES - 1), 8'(rAt));
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        rst();
        chk("edgeRst", 8'h01, 8'(eBit));
        chk("maskRst", 8'h01, 8'(gMask));
        chk("nmiRst", 8'h01, 8'(nDis));
        srcA <= 1'b1;
        srcN <= 1'b1;
        cyc(2);
        srcA <= 1'b0;
        cyc(4);
        chk("held", 8'h00, 8'(inEntry));
        srcN <= 1'b0;
        wrm(1'b0);
        isr(SRC_EXT);
        chk("restore", 8'h00, 8'(gMask));
        cyc(5);
        chk("once", 8'h00, 8'(inEntry));
        repeat (4) begin
            lfsr = nxt(lfsr);
            srcA <= 1'b1;
            srcB <= lfsr[2];
            cyc(1 + int'(lfsr[1:0]));
            srcA <= 1'b0;
            srcB <= 1'b0;
            isr(SRC_EXT);
            cyc(3);
            chk("single", 8'h00, 8'(inEntry));
        end
        wrm(1'b1);
        nClr <= 1'b1;
        cyc(1);
        nClr <= 1'b0;
        srcN <= 1'b1;
        srcA <= 1'b1;
        cyc(1);
        chk("nmiClr", 8'h00, 8'(nDis));
        srcN <= 1'b0;
        srcA <= 1'b0;
        isr(SRC_NMI);
        cyc(3);
        chk("deferred", 8'h00, 8'(inEntry));
        wrm(1'b0);
        isr(SRC_EXT);
        wre(1'b0);
        chk("protect", 8'h01, 8'(eBit));
        rst();
        wre(1'b0);
        chk("edgeWr", 8'h00, 8'(eBit));
        wrm(1'b0);
        otherReq <= 1'b1;
        srcA <= 1'b1;
        isr(SRC_EXT);
        srcA <= 1'b0;
        isr(SRC_EXT);
        otherReq <= 1'b0;
        isr(SRC_OTHER);
        cyc(5);
        chk("idle", 8'h00, 8'(inEntry));
        summarize();
    end
endmodule
